// ### logic/acfg_cfg.svh
// Offsets, field positions, reset values and codes of the converter configuration bank.
`ifndef ACFG_CFG_SVH
`define ACFG_CFG_SVH

`define ACFG_ADDR_RESET 7'h00
`define ACFG_ADDR_TIMING 7'h02
`define ACFG_ADDR_DRIVER 7'h03
`define ACFG_ADDR_FORMAT 7'h04

`define ACFG_RST_VAL 8'h00
`define ACFG_SWRST_BIT 7
`define ACFG_TIM_MASK 8'h0f
`define ACFG_DRV_MASK 8'h7f
`define ACFG_FMT_MASK 8'h3f

`define ACFG_INVERT_BIT 3
`define ACFG_PHASE_MSB 2
`define ACFG_PHASE_LSB 1
`define ACFG_STAB_BIT 0
`define ACFG_CUR_MSB 6
`define ACFG_CUR_LSB 4
`define ACFG_TERM_BIT 3
`define ACFG_OFF_BIT 2
`define ACFG_STD_MSB 1
`define ACFG_STD_LSB 0
`define ACFG_TEST_MSB 5
`define ACFG_TEST_LSB 3
`define ACFG_ALTPOL_BIT 2
`define ACFG_SCRAM_BIT 1
`define ACFG_TWOS_BIT 0

`define ACFG_HDR_LAST 5'h07
`define ACFG_FRAME_LAST 5'h0f

// Driver currents in microamps.
`define ACFG_CUR_3500 14'h0dac
`define ACFG_CUR_4000 14'h0fa0
`define ACFG_CUR_4500 14'h1194
`define ACFG_CUR_3000 14'h0bb8
`define ACFG_CUR_2500 14'h09c4
`define ACFG_CUR_2100 14'h0834
`define ACFG_CUR_1750 14'h06d6
`define ACFG_CUR_NONE 14'h0000

`define ACFG_TP_OFF 3'h0
`define ACFG_TP_ZEROS 3'h1
`define ACFG_TP_ONES 3'h3
`define ACFG_TP_CHECK 3'h5
`define ACFG_TP_ALT 3'h7
`define ACFG_WORD_CHECK_A 13'h1555
`define ACFG_WORD_CHECK_B 13'h0aaa
`define ACFG_WORD_ONES 13'h1fff
`define ACFG_WORD_ZEROS 13'h0000
`define ACFG_ALTPOL_FLIP 12'haaa

`endif

// ### logic/acfg_pkg.sv
// Types shared by the converter configuration bank.
package acfg_pkg;
	typedef enum logic [1:0] {
		ACFG_SPI_SHIFT = 2'h0,
		ACFG_SPI_DONE  = 2'h1
	} acfg_spi_state_t;

	typedef struct packed {
		acfg_spi_state_t state;
		logic            sck_prev;
		logic [4:0]      cnt;
		logic [15:0]     shift_in;
		logic [7:0]      hdr;
		logic [7:0]      shift_out;
		logic            rd_active;
		logic            sdo_oe;
		logic            hdr_valid;
		logic            frame_valid;
	} acfg_spi_t;

	typedef struct packed {
		logic        phase;
		logic        valid;
		logic [12:0] word;
	} acfg_pat_t;

	typedef struct packed {
		logic [7:0]  timing;
		logic [7:0]  driver;
		logic [7:0]  format;
		logic [13:0] cur_ua;
		logic [2:0]  delay_eighths;
		logic        out_clock;
		logic        data_oe;
	} acfg_main_t;
endpackage

// ### logic/acfg_frame_if.sv
// Decoded serial frame passed from the serial port to the register bank.
`timescale 1ns/1ps
`default_nettype none
interface acfg_frame_if;
	logic       hdr_valid;
	logic       frame_valid;
	logic       rw;
	logic [6:0] addr;
	logic [7:0] data;
	logic [7:0] rd_data;
	modport port (output hdr_valid, frame_valid, rw, addr, data, input rd_data);
	modport bank (input hdr_valid, frame_valid, rw, addr, data, output rd_data);
endinterface
`default_nettype wire

// ### logic/acfg_spi_port.sv
// Serial port: frames the 16-bit word and shifts read data out on the open-drain line.
`timescale 1ns/1ps
`default_nettype none
`include "acfg_cfg.svh"
module acfg_spi_port (
	// Clock and reset
	input  wire logic   i_clk_sys,
	input  wire logic   i_rst,
	// Serial pins
	input  wire logic   i_cs_n,
	input  wire logic   i_sck,
	input  wire logic   i_sdi,
	output logic        o_sdo_oe,
	// Frame to the bank
	acfg_frame_if.port  frm
);
	acfg_pkg::acfg_spi_t r_reg;
	acfg_pkg::acfg_spi_t r_next;
	logic                rise;

	assign rise = i_sck & ~r_reg.sck_prev;

	always_comb begin
		r_next = r_reg;
		r_next.sck_prev = i_sck;
		r_next.hdr_valid = 1'b0;
		r_next.frame_valid = 1'b0;
		if (i_cs_n) begin
			r_next.state = acfg_pkg::ACFG_SPI_SHIFT;
			r_next.cnt = 5'h00;
			r_next.rd_active = 1'b0;
		end else begin
			// Read data is loaded once the header is known.
			if (r_reg.hdr_valid && r_reg.hdr[7]) begin
				r_next.shift_out = frm.rd_data;
				r_next.rd_active = 1'b1;
			end
			unique case (r_reg.state)
				acfg_pkg::ACFG_SPI_SHIFT: begin
					if (rise) begin
						r_next.shift_in = {r_reg.shift_in[14:0], i_sdi};
						r_next.cnt = r_reg.cnt + 5'h01;
						if (r_reg.rd_active) begin
							r_next.shift_out = {r_reg.shift_out[6:0], 1'b0};
						end
						if (r_reg.cnt == `ACFG_HDR_LAST) begin
							r_next.hdr = {r_reg.shift_in[6:0], i_sdi};
							r_next.hdr_valid = 1'b1;
						end
						if (r_reg.cnt == `ACFG_FRAME_LAST) begin
							r_next.frame_valid = 1'b1;
							r_next.state = acfg_pkg::ACFG_SPI_DONE;
						end
					end
				end
				// Edges after the sixteenth are ignored until the frame ends.
				acfg_pkg::ACFG_SPI_DONE: begin
					r_next.state = acfg_pkg::ACFG_SPI_DONE;
				end
			endcase
		end
		r_next.sdo_oe = r_next.rd_active & ~r_next.shift_out[7];
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign frm.hdr_valid = r_reg.hdr_valid;
	assign frm.frame_valid = r_reg.frame_valid;
	assign frm.rw = r_reg.hdr[7];
	assign frm.addr = r_reg.hdr[6:0];
	assign frm.data = r_reg.shift_in[7:0];
	assign o_sdo_oe = r_reg.sdo_oe;
endmodule
`default_nettype wire

// ### logic/acfg_pattern.sv
// Output word shaper: number format, randomizer, alternate polarity and test patterns.
`timescale 1ns/1ps
`default_nettype none
`include "acfg_cfg.svh"
module acfg_pattern #(
	parameter int unsigned W = 12
) (
	// Clock and reset
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst,
	// Settings
	input  wire logic [2:0]   i_test_sel,
	input  wire logic         i_alt_pol,
	input  wire logic         i_scramble,
	input  wire logic         i_signed,
	// Sample in
	input  wire logic         i_valid,
	input  wire logic [W-1:0] i_bits,
	input  wire logic         i_ovf,
	// Sample out
	output logic              o_valid,
	output logic [W:0]        o_word
);
	acfg_pkg::acfg_pat_t r_reg;
	acfg_pkg::acfg_pat_t r_next;

	function automatic logic [W-1:0] shape(input logic [W-1:0] d, input logic ph);
		logic [W-1:0] v;
		v = d;
		if (i_signed && !i_alt_pol) begin
			v[W-1] = ~v[W-1];
		end
		if (i_scramble) begin
			v[W-1:1] = v[W-1:1] ^ {(W-1){v[0]}};
		end
		if (i_alt_pol && ph) begin
			v = v ^ `ACFG_ALTPOL_FLIP;
		end
		return v;
	endfunction

	always_comb begin
		r_next = r_reg;
		r_next.valid = i_valid;
		if (i_valid) begin
			r_next.phase = ~r_reg.phase;
			unique case (i_test_sel)
				`ACFG_TP_ZEROS: r_next.word = `ACFG_WORD_ZEROS;
				`ACFG_TP_ONES: r_next.word = `ACFG_WORD_ONES;
				`ACFG_TP_CHECK: r_next.word = r_reg.phase ? `ACFG_WORD_CHECK_B
					: `ACFG_WORD_CHECK_A;
				`ACFG_TP_ALT: r_next.word = r_reg.phase ? `ACFG_WORD_ONES
					: `ACFG_WORD_ZEROS;
				default: r_next.word = {i_ovf, shape(i_bits, r_reg.phase)};
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_valid = r_reg.valid;
	assign o_word = r_reg.word;
endmodule
`default_nettype wire

// ### logic/acfg_regs.sv
// Configuration bank of a dual converter: timing, driver mode and data format registers.
`timescale 1ns/1ps
`default_nettype none
`include "acfg_cfg.svh"
module acfg_regs #(
	parameter int unsigned SAMPLE_W = 12
) (
	// Clock and reset
	input  wire logic                i_clk_sys,
	input  wire logic                i_rst,
	// Serial port pins
	input  wire logic                i_cs_n,
	input  wire logic                i_sck,
	input  wire logic                i_sdi,
	output logic                     o_sdo_out,
	output logic                     o_sdo_oe,
	// Converter clock and samples
	input  wire logic                i_sample_clock,
	input  wire logic                i_sample_valid,
	input  wire logic [SAMPLE_W-1:0] i_sample_bits,
	input  wire logic                i_overflow_flag,
	// Output clock controls
	output logic                     o_output_clock,
	output logic                     o_out_clock_invert,
	output logic [1:0]               o_out_clock_phase_sel,
	output logic [2:0]               o_clock_delay_eighths,
	output logic                     o_duty_cycle_stabilizer_en,
	// Driver controls
	output logic [2:0]               o_diff_drive_current_sel,
	output logic [13:0]              o_drive_current_ua,
	output logic                     o_internal_termination_en,
	output logic                     o_outputs_disable,
	output logic                     o_data_oe,
	output logic [1:0]               o_output_standard_sel,
	// Format controls
	output logic [2:0]               o_test_pattern_sel,
	output logic                     o_alt_bit_polarity_en,
	output logic                     o_output_randomizer_en,
	output logic                     o_signed_format_sel,
	// Shaped output words
	output logic                     o_sample_valid,
	output logic [SAMPLE_W-1:0]      o_sample_bits,
	output logic                     o_overflow_flag
);
	acfg_pkg::acfg_main_t r_reg;
	acfg_pkg::acfg_main_t r_next;
	acfg_frame_if         frm ();
	logic                 sdo_oe_q;
	logic                 pat_valid;
	logic [SAMPLE_W:0]    pat_word;

	// Driver current in microamps; the unused code reads as zero.
	function automatic logic [13:0] cur_ua(
		input logic [2:0] sel,
		input logic       term
	);
		logic [13:0] base;
		base = `ACFG_CUR_NONE;
		unique case (sel)
			3'h0: base = `ACFG_CUR_3500;
			3'h1: base = `ACFG_CUR_4000;
			3'h2: base = `ACFG_CUR_4500;
			3'h3: base = `ACFG_CUR_NONE;
			3'h4: base = `ACFG_CUR_3000;
			3'h5: base = `ACFG_CUR_2500;
			3'h6: base = `ACFG_CUR_2100;
			3'h7: base = `ACFG_CUR_1750;
		endcase
		if (term) begin
			base = {base[12:0], 1'b0};
		end
		return base;
	endfunction

	// Readback; unmapped and write-only addresses read as zero.
	function automatic logic [7:0] reg_read(
		input logic [6:0]           a,
		input acfg_pkg::acfg_main_t s
	);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			`ACFG_ADDR_TIMING: v = s.timing;
			`ACFG_ADDR_DRIVER: v = s.driver;
			`ACFG_ADDR_FORMAT: v = s.format;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	acfg_spi_port u_spi (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_cs_n    (i_cs_n),
		.i_sck     (i_sck),
		.i_sdi     (i_sdi),
		.o_sdo_oe  (sdo_oe_q),
		.frm       (frm.port)
	);

	assign frm.rd_data = reg_read(frm.addr, r_reg);

	always_comb begin
		r_next = r_reg;
		// Reads never reach this branch, so they leave the bank unchanged.
		if (frm.frame_valid && !frm.rw) begin
			unique case (frm.addr)
				`ACFG_ADDR_RESET: begin
					if (frm.data[`ACFG_SWRST_BIT]) begin
						r_next.timing = `ACFG_RST_VAL;
						r_next.driver = `ACFG_RST_VAL;
						r_next.format = `ACFG_RST_VAL;
					end
				end
				`ACFG_ADDR_TIMING: begin
					r_next.timing = frm.data & `ACFG_TIM_MASK;
				end
				`ACFG_ADDR_DRIVER: begin
					r_next.driver = frm.data & `ACFG_DRV_MASK;
				end
				`ACFG_ADDR_FORMAT: begin
					r_next.format = frm.data & `ACFG_FMT_MASK;
				end
				default: begin
					r_next.timing = r_reg.timing;
				end
			endcase
		end
		// Derived controls follow the stored fields in the same cycle, except out_clock, which takes the invert bit one cycle later.
		r_next.cur_ua = cur_ua(
			r_next.driver[`ACFG_CUR_MSB:`ACFG_CUR_LSB],
			r_next.driver[`ACFG_TERM_BIT]);
		r_next.delay_eighths = {1'b0,
			r_next.timing[`ACFG_PHASE_MSB:`ACFG_PHASE_LSB]};
		r_next.data_oe = ~r_next.driver[`ACFG_OFF_BIT];
		r_next.out_clock = i_sample_clock ^ r_reg.timing[`ACFG_INVERT_BIT];
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			r_reg <= '0;
			r_reg.cur_ua <= `ACFG_CUR_3500;
			r_reg.data_oe <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	acfg_pattern #(
		.W (SAMPLE_W)
	) u_pat (
		.i_clk_sys  (i_clk_sys),
		.i_rst      (i_rst),
		.i_test_sel (r_reg.format[`ACFG_TEST_MSB:`ACFG_TEST_LSB]),
		.i_alt_pol  (r_reg.format[`ACFG_ALTPOL_BIT]),
		.i_scramble (r_reg.format[`ACFG_SCRAM_BIT]),
		.i_signed   (r_reg.format[`ACFG_TWOS_BIT]),
		.i_valid    (i_sample_valid),
		.i_bits     (i_sample_bits),
		.i_ovf      (i_overflow_flag),
		.o_valid    (pat_valid),
		.o_word     (pat_word)
	);

	// Open drain: the line is only ever pulled low.
	assign o_sdo_out = 1'b0;
	assign o_sdo_oe = sdo_oe_q;

	assign o_output_clock = r_reg.out_clock;
	assign o_out_clock_invert = r_reg.timing[`ACFG_INVERT_BIT];
	assign o_out_clock_phase_sel = r_reg.timing[`ACFG_PHASE_MSB:`ACFG_PHASE_LSB];
	assign o_clock_delay_eighths = r_reg.delay_eighths;
	assign o_duty_cycle_stabilizer_en = r_reg.timing[`ACFG_STAB_BIT];

	assign o_diff_drive_current_sel = r_reg.driver[`ACFG_CUR_MSB:`ACFG_CUR_LSB];
	assign o_drive_current_ua = r_reg.cur_ua;
	assign o_internal_termination_en = r_reg.driver[`ACFG_TERM_BIT];
	assign o_outputs_disable = r_reg.driver[`ACFG_OFF_BIT];
	assign o_data_oe = r_reg.data_oe;
	assign o_output_standard_sel = r_reg.driver[`ACFG_STD_MSB:`ACFG_STD_LSB];

	assign o_test_pattern_sel = r_reg.format[`ACFG_TEST_MSB:`ACFG_TEST_LSB];
	assign o_alt_bit_polarity_en = r_reg.format[`ACFG_ALTPOL_BIT];
	assign o_output_randomizer_en = r_reg.format[`ACFG_SCRAM_BIT];
	assign o_signed_format_sel = r_reg.format[`ACFG_TWOS_BIT];

	assign o_sample_valid = pat_valid;
	assign o_sample_bits = pat_word[SAMPLE_W-1:0];
	assign o_overflow_flag = pat_word[SAMPLE_W];
endmodule
`default_nettype wire

// ### test/acfg_regs_checker.sv
// Port-level assertions for the converter configuration bank.
`timescale 1ns/1ps
`default_nettype none
module acfg_regs_checker #(
	parameter int unsigned SAMPLE_W = 12
) (
	// Clock, reset and stimulus
	input wire logic                i_clk_sys,
	input wire logic                i_rst,
	input wire logic                i_cs_n,
	input wire logic                i_sample_clock,
	input wire logic                i_sample_valid,
	// Observed outputs
	input wire logic                o_sdo_out,
	input wire logic                o_sdo_oe,
	input wire logic                o_output_clock,
	input wire logic                o_out_clock_invert,
	input wire logic [1:0]          o_out_clock_phase_sel,
	input wire logic [2:0]          o_clock_delay_eighths,
	input wire logic [2:0]          o_diff_drive_current_sel,
	input wire logic [13:0]         o_drive_current_ua,
	input wire logic                o_internal_termination_en,
	input wire logic                o_outputs_disable,
	input wire logic                o_data_oe,
	input wire logic [2:0]          o_test_pattern_sel,
	input wire logic                o_sample_valid,
	input wire logic [SAMPLE_W-1:0] o_sample_bits,
	input wire logic                o_overflow_flag
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	function automatic logic [13:0] ua(input logic [2:0] s, input logic t);
		logic [13:0] c [8];
		c = '{14'h0dac, 14'h0fa0, 14'h1194, 14'h0000, 14'h0bb8, 14'h09c4, 14'h0834, 14'h06d6};
		return t ? (c[s] << 1) : c[s];
	endfunction

	sequence s_zeros;
		o_sample_valid && ($past(o_test_pattern_sel) == 3'h1);
	endsequence
	sequence s_ones;
		o_sample_valid && ($past(o_test_pattern_sel) == 3'h3);
	endsequence

	a_sdo_low: assert property (o_sdo_out == 1'b0)
		else $error("serial output drives high");
	a_sdo_release: assert property ($past(i_cs_n) |-> !o_sdo_oe)
		else $error("serial output held after deselect");
	a_delay_code: assert property (o_clock_delay_eighths == {1'b0, o_out_clock_phase_sel})
		else $error("clock delay does not match phase code");
	a_drive_ua: assert property (o_drive_current_ua == ua(o_diff_drive_current_sel, o_internal_termination_en))
		else $error("driver current wrong");
	a_data_oe: assert property (o_data_oe == !o_outputs_disable)
		else $error("data enable disagrees with disable bit");
	a_clk_inv: assert property (!$past(i_rst) |-> o_output_clock == ($past(i_sample_clock) ^ $past(o_out_clock_invert)))
		else $error("output clock polarity wrong");
	a_word_valid: assert property (o_sample_valid == $past(i_sample_valid))
		else $error("sample valid not one cycle late");
	a_pat_zeros: assert property (s_zeros |-> {o_overflow_flag, o_sample_bits} == 13'h0000)
		else $error("zeros pattern wrong");
	a_pat_ones: assert property (s_ones |-> {o_overflow_flag, o_sample_bits} == 13'h1fff)
		else $error("ones pattern wrong");
	a_cfg_hold: assert property (i_cs_n [*3] |=> $stable({o_out_clock_invert, o_diff_drive_current_sel, o_test_pattern_sel}))
		else $error("settings changed without a frame");
endmodule

bind acfg_regs acfg_regs_checker #(.SAMPLE_W(SAMPLE_W)) u_chk (.i_clk_sys, .i_rst, .i_cs_n,
	.i_sample_clock, .i_sample_valid, .o_sdo_out, .o_sdo_oe, .o_output_clock, .o_out_clock_invert,
	.o_out_clock_phase_sel, .o_clock_delay_eighths, .o_diff_drive_current_sel, .o_drive_current_ua,
	.o_internal_termination_en, .o_outputs_disable, .o_data_oe, .o_test_pattern_sel,
	.o_sample_valid, .o_sample_bits, .o_overflow_flag);
`default_nettype wire

// ### test/acfg_spi_host.sv
// Serial host model that frames 16-bit words toward the bank.
`timescale 1ns/1ps
`default_nettype none
module acfg_spi_host (
	// Clock and returned serial data
	input  wire logic i_clk_sys,
	input  wire logic i_sdo,
	// Serial lines toward the bank
	output var logic  o_cs_n,
	output var logic  o_sck,
	output var logic  o_sdi
);
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_sdi = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask

	// Sends n bits MSB first; read bits are taken just before rises 9 to 16.
	task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		o_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_sdi = w[15-i];
			wait_clk(4);
			if (i >= 8) rd[15-i] = i_sdo;
			o_sck = 1'b1;
			wait_clk(4);
			o_sck = 1'b0;
		end
		wait_clk(4);
		o_cs_n = 1'b1;
		o_sdi = ~o_sdi;
		wait_clk(2);
	endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench of the configuration bank against a reference model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        i_clk_sys, i_rst, i_cs_n, i_sck, i_sdi, i_sample_clock, i_sample_valid;
	logic        i_overflow_flag, o_sdo_out, o_sdo_oe, o_output_clock, o_out_clock_invert;
	logic        o_duty_cycle_stabilizer_en, o_internal_termination_en, o_outputs_disable;
	logic        o_data_oe, o_alt_bit_polarity_en, o_output_randomizer_en;
	logic        o_signed_format_sel, o_sample_valid, o_overflow_flag;
	logic [1:0]  o_out_clock_phase_sel, o_output_standard_sel;
	logic [2:0]  o_clock_delay_eighths, o_diff_drive_current_sel, o_test_pattern_sel;
	logic [13:0] o_drive_current_ua;
	logic [11:0] i_sample_bits, o_sample_bits;
	logic [7:0]  rd;
	int          failures, n_tests, ph;
	int          mdl [0:7];
	int          q [$];
	wire         sdo_w = o_sdo_oe ? o_sdo_out : 1'b1;

	acfg_regs #(.SAMPLE_W(12)) dut (.i_clk_sys, .i_rst, .i_cs_n, .i_sck, .i_sdi, .o_sdo_out,
		.o_sdo_oe, .i_sample_clock, .i_sample_valid, .i_sample_bits, .i_overflow_flag,
		.o_output_clock, .o_out_clock_invert, .o_out_clock_phase_sel, .o_clock_delay_eighths,
		.o_duty_cycle_stabilizer_en, .o_diff_drive_current_sel, .o_drive_current_ua,
		.o_internal_termination_en, .o_outputs_disable, .o_data_oe, .o_output_standard_sel,
		.o_test_pattern_sel, .o_alt_bit_polarity_en, .o_output_randomizer_en,
		.o_signed_format_sel, .o_sample_valid, .o_sample_bits, .o_overflow_flag);
	acfg_spi_host host (.i_clk_sys, .i_sdo(sdo_w), .o_cs_n(i_cs_n), .o_sck(i_sck), .o_sdi(i_sdi));

	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) i_sample_clock <= #1 ~i_sample_clock;

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic int ua(input int v);
		int c [8];
		c = '{3500, 4000, 4500, 0, 3000, 2500, 2100, 1750};
		return c[v[6:4]] * (v[3] ? 2 : 1);
	endfunction

	task automatic wr(input int a, input int d);
		host.xfer({1'b0, a[6:0], d[7:0]}, 16, rd);
		if (a == 0 && d[7]) mdl = '{default: 0};
		else if (a >= 2 && a <= 4) mdl[a] = d & (a == 2 ? 'h0f : a == 3 ? 'h7f : 'h3f);
	endtask

	task automatic rdchk(input int a);
		host.xfer({1'b1, a[6:0], 8'h5a}, 16, rd);
		chk(rd, (a >= 2 && a <= 4) ? mdl[a] : 0);
	endtask

	task automatic outs;
		int t, v, f;
		t = mdl[2];
		v = mdl[3];
		f = mdl[4];
		chk({o_out_clock_invert, o_out_clock_phase_sel, o_clock_delay_eighths,
			o_duty_cycle_stabilizer_en}, {t[3], t[2:1], 1'b0, t[2:1], t[0]});
		chk({o_diff_drive_current_sel, o_internal_termination_en, o_outputs_disable, o_data_oe,
			o_output_standard_sel}, {v[6:2], ~v[2], v[1:0]});
		chk(o_drive_current_ua, ua(v));
		chk({o_test_pattern_sel, o_alt_bit_polarity_en, o_output_randomizer_en,
			o_signed_format_sel}, f[5:0]);
	endtask

	// One converter word in, shaped word compared once it has been taken and registered.
	task automatic smp(input int fm);
		int b, e;
		b = $urandom;
		e = b[12:0];
		i_sample_bits = b[11:0];
		i_overflow_flag = b[12];
		i_sample_valid = 1'b1;
		case (fm[5:3])
			1: q.push_back(0);
			3: q.push_back('h1fff);
			5: q.push_back(ph ? 'h0aaa : 'h1555);
			7: q.push_back(ph ? 'h1fff : 0);
			default: begin
				if (fm[0] && !fm[2]) e[11] = ~e[11];
				if (fm[1]) e[11:1] = e[11:1] ^ {11{e[0]}};
				if (fm[2] && ph) e[11:0] = e[11:0] ^ 12'haaa;
				q.push_back(e);
			end
		endcase
		ph = 1 - ph;
		host.wait_clk(1);
		i_sample_valid = 1'b0;
		host.wait_clk(2);
		chk({o_overflow_flag, o_sample_bits}, q.pop_front());
	endtask

	initial begin
		int a, d;
		int pats [9];
		pats = '{'h00, 'h01, 'hc8, 'h18, 'h28, 'h38, 'h03, 'h06, 'h07};
		i_rst = 1'b1;
		i_sample_clock = 1'b0;
		i_sample_valid = 1'b0;
		i_sample_bits = 12'h000;
		i_overflow_flag = 1'b0;
		failures = 0;
		n_tests = 0;
		ph = 0;
		mdl = '{default: 0};
		void'($urandom(32'h43cae4ca));
		repeat (3) @(posedge i_clk_sys);
		#1 i_rst = 1'b0;
		outs();
		for (a = 0; a < 6; a++) rdchk(a);
		$display("test reset done");
		wr(1, 3);
		for (int i = 0; i < 12; i++) begin
			a = 2 + $urandom_range(2);
			d = $urandom_range(255);
			if (a == 2 && d[2:1] != 0) d[0] = 1'b1;
			if (a == 4 && d[5:4] != 0) d[3] = 1'b1;
			wr(a, d);
			outs();
			rdchk(a);
		end
		wr(5, 'hff);
		wr('h7f, 'hff);
		rdchk('h7f);
		for (a = 0; a < 6; a++) rdchk(a);
		outs();
		$display("test random traffic done");
		for (d = 0; d < 16; d++) begin
			wr(3, d << 3);
			outs();
		end
		$display("test driver current done");
		host.xfer({1'b0, 7'h02, 8'h0e}, 15, rd);
		outs();
		rdchk(2);
		$display("test aborted frame done");
		foreach (pats[k]) begin
			wr(4, pats[k]);
			repeat (4) smp(pats[k] & 'h3f);
		end
		$display("test patterns done");
		wr(0, 'h80);
		outs();
		for (a = 2; a < 5; a++) rdchk(a);
		$display("test soft reset done");
		close_out();
	end

	initial begin
		#2000000;
		failures++;
		close_out();
	end
endmodule
`default_nettype wire
